// >>> rtl/watchdog_monitor_counters.sv
// Monitor section: three gated down-counters, watchdog relay drive and status port
// Summary of operation
// (RULE1) Three-bit mode picks modes 0 to 5; top bit ignored for modes 2 and 3.
// (RULE2) Mode 0: output low on count write, high at zero until next write.
// (RULE3) Mode 0: decrementing begins once gate is high or a gate rise has been seen, then continues.
// (RULE4) Mode 1: output low on clock after gate rise, high again at zero.
// (RULE5) Mode 1: another gate rise reloads the count and restarts the low pulse.
// (RULE6) Mode 2: divide by N, one clock low each period, then reload.
// (RULE7) Mode 2: the cycle repeats forever and stops only while gate is low.
// (RULE8) Mode 3: square wave, odd N gives (N+1)/2 high and (N-1)/2 low.
// (RULE9) Mode 4: count write starts counting, one clock low at zero, rewrite to repeat.
// (RULE10) Mode 4: a low gate holds the count.
// (RULE11) Mode 5: gate rise starts count, one clock low at zero; retrigger restarts.
// (RULE12) Software arms the watchdog: counter 2, mode 0, binary, low byte, then count.
// (RULE13) Software enables the watchdog through a serial port modem control bit.
// (RULE14) Software rewrites counter 2 low byte before it reaches zero.
// (RULE15) Status bit 0 is 1 when temperature exceeds the limit.
// (RULE16) Status bit 1 is 1 only while every supply is inside its window.
// (RULE17) Status bit 2 is 0 when any supply is too low.
// (RULE18) Status bit 3 is 0 when any supply is too high.
// (RULE19) Status bit 4 is watchdog output, true if invert option set, else complement.
// (RULE20) Status bit 5 is 0 while relays are energized, 1 otherwise.
// (RULE21) Status bits 6 and 7 always read 0.
// (RULE22) Offsets 0-2 counters, 3 write-only control, 4 read-only status.
// (RULE23) Control word: select 7:6, access 5:4, mode 3:1, decimal flag bit 0.
// (RULE24) Access: 00 latch, 01 low byte, 10 high byte, 11 low then high.
// (RULE25) Decimal flag 0 counts binary, 1 counts BCD; mode 3 halves and counts in binary whatever the flag.
// (RULE26) Status reads have no side effect and show live conditions.
`timescale 1ns/10ps
`include "mon_cfg.svh"
module watchdog_monitor_counters (
    input wire logic clk,
    input wire logic srst,
    input wire mon_pkg::io_req_t io_req,
    input wire mon_pkg::pins_t pins,
    input wire logic dog_enable,
    output logic [7:0] io_rdata,
    output logic [2:0] ctr_out,
    output logic relay_drive
);
    import mon_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [15:0] dec_count(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (borrow) begin
                    if (r[4*k +: 4] == 4'h0) begin
                        r[4*k +: 4] = 4'h9;
                    end else begin
                        r[4*k +: 4] = r[4*k +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : dec_count

    function automatic logic [15:0] half_count(input logic [15:0] v, input logic upper);
        logic [16:0] s;
        s = {1'b0, v} + {16'h0000, upper};
        return s[16:1];
    endfunction : half_count

    function automatic mode_t eff_mode(input logic [2:0] m);
        mode_t r;
        r = mode_t'(m);
        if (m[1]) begin
            r = mode_t'({1'b0, m[1:0]}); // RULE1
        end
        return r;
    endfunction : eff_mode

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    pins_t s1_q;
    pins_t s2_q;
    pins_t s3_q;
    logic [2:0] tick;
    logic [2:0] gate_rise;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign tick = s2_q.cclk & ~s3_q.cclk;
    assign gate_rise = s2_q.gate & ~s3_q.gate;

    ////////////////////////////////////////////////////////////////////////////////
    // Host decode

    ctl_t ctl_q [`CTR_NUM];
    logic [15:0] init_q [`CTR_NUM];
    logic [15:0] count_q [`CTR_NUM];
    logic [15:0] latch_q [`CTR_NUM];
    logic [2:0] wr_hi_q;
    logic [2:0] rd_hi_q;
    logic [2:0] latched_q;
    logic [2:0] ctl_hit;
    logic [2:0] latch_hit;
    logic [2:0] load_done;
    logic [1:0] w_sel;
    logic [1:0] w_acc;
    logic ctl_wr;

    assign ctl_wr = io_req.wr && io_req.addr == `OFS_CTRL; // RULE22
    assign w_sel = io_req.wdata[`CTL_SEL_HI:`CTL_SEL_LO]; // RULE23
    assign w_acc = io_req.wdata[`CTL_ACC_HI:`CTL_ACC_LO];

    always_comb begin
        for (int i = 0; i < `CTR_NUM; i++) begin
            ctl_hit[i] = ctl_wr && w_sel == 2'(i) && w_acc != `ACC_LATCH;
            latch_hit[i] = ctl_wr && w_sel == 2'(i) && w_acc == `ACC_LATCH; // RULE24
            load_done[i] = io_req.wr && io_req.addr == 3'(i)
                && (ctl_q[i].acc != `ACC_BOTH || wr_hi_q[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control word and count loading

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_hi_q <= 3'h0;
            for (int i = 0; i < `CTR_NUM; i++) begin
                ctl_q[i] <= '{acc: `ACC_LSB, mode: MODE_TC, bcd: 1'b0};
                init_q[i] <= `COUNT_RST;
            end
        end else begin
            for (int i = 0; i < `CTR_NUM; i++) begin
                if (ctl_hit[i]) begin
                    ctl_q[i].acc <= w_acc;
                    ctl_q[i].mode <= eff_mode(io_req.wdata[`CTL_MODE_HI:`CTL_MODE_LO]);
                    ctl_q[i].bcd <= io_req.wdata[`CTL_BCD]; // RULE25
                    wr_hi_q[i] <= 1'b0;
                end else if (io_req.wr && io_req.addr == 3'(i)) begin
                    case (ctl_q[i].acc) // RULE24
                        `ACC_LSB: init_q[i] <= {8'h00, io_req.wdata}; // RULE12
                        `ACC_MSB: init_q[i] <= {io_req.wdata, 8'h00};
                        `ACC_BOTH: begin
                            if (wr_hi_q[i]) begin
                                init_q[i][15:8] <= io_req.wdata;
                            end else begin
                                init_q[i][7:0] <= io_req.wdata;
                            end
                            wr_hi_q[i] <= ~wr_hi_q[i];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counting engines

    logic [2:0] out_q;
    logic [2:0] pend_q;
    logic [2:0] run_q;
    logic [2:0] trig_q;
    logic [2:0] armed_q;
    logic [2:0] pulse_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            out_q <= 3'h7;
            pend_q <= 3'h0;
            run_q <= 3'h0;
            trig_q <= 3'h0;
            armed_q <= 3'h0;
            pulse_q <= 3'h0;
            for (int i = 0; i < `CTR_NUM; i++) begin
                count_q[i] <= `COUNT_RST;
            end
        end else begin
            for (int i = 0; i < `CTR_NUM; i++) begin
                if (ctl_hit[i]) begin
                    out_q[i] <= eff_mode(io_req.wdata[`CTL_MODE_HI:`CTL_MODE_LO]) != MODE_TC;
                    pend_q[i] <= 1'b0;
                    run_q[i] <= 1'b0;
                    armed_q[i] <= 1'b0;
                    pulse_q[i] <= 1'b0;
                end else if (load_done[i]) begin
                    pend_q[i] <= 1'b1;
                    if (ctl_q[i].mode == MODE_TC) begin
                        out_q[i] <= 1'b0; // RULE2
                        run_q[i] <= 1'b0;
                        armed_q[i] <= 1'b0;
                    end
                    if (ctl_q[i].mode == MODE_SW_STROBE) begin
                        out_q[i] <= 1'b1; // RULE9
                        pulse_q[i] <= 1'b0;
                    end
                end else if (tick[i]) begin
                    trig_q[i] <= 1'b0;
                    case (ctl_q[i].mode)
                        MODE_TC: begin
                            if (pend_q[i]) begin
                                count_q[i] <= init_q[i];
                                pend_q[i] <= 1'b0;
                                run_q[i] <= 1'b1;
                            end else if (run_q[i] && (armed_q[i] || trig_q[i] || s2_q.gate[i])) begin
                                armed_q[i] <= 1'b1; // RULE3
                                count_q[i] <= dec_count(count_q[i], ctl_q[i].bcd);
                                if (count_q[i] == 16'h0001) begin
                                    out_q[i] <= 1'b1; // RULE2
                                    run_q[i] <= 1'b0;
                                end
                            end
                        end
                        MODE_ONESHOT: begin
                            if (trig_q[i]) begin
                                count_q[i] <= init_q[i]; // RULE5
                                out_q[i] <= 1'b0; // RULE4
                                run_q[i] <= 1'b1;
                                pend_q[i] <= 1'b0;
                            end else if (run_q[i]) begin
                                count_q[i] <= dec_count(count_q[i], ctl_q[i].bcd);
                                if (count_q[i] == 16'h0001) begin
                                    out_q[i] <= 1'b1; // RULE4
                                    run_q[i] <= 1'b0;
                                end
                            end
                        end
                        MODE_RATE: begin
                            if (!s2_q.gate[i]) begin
                                out_q[i] <= 1'b1; // RULE7
                            end else if (pend_q[i] || trig_q[i]) begin
                                count_q[i] <= init_q[i];
                                pend_q[i] <= 1'b0;
                                run_q[i] <= 1'b1;
                                out_q[i] <= 1'b1;
                            end else if (run_q[i]) begin
                                if (count_q[i] == 16'h0001) begin
                                    out_q[i] <= 1'b0; // RULE6
                                    count_q[i] <= init_q[i];
                                end else begin
                                    out_q[i] <= 1'b1;
                                    count_q[i] <= dec_count(count_q[i], ctl_q[i].bcd);
                                end
                            end
                        end
                        MODE_SQUARE: begin
                            if (!s2_q.gate[i]) begin
                                out_q[i] <= 1'b1;
                            end else if (pend_q[i] || trig_q[i]) begin
                                count_q[i] <= half_count(init_q[i], 1'b1); // RULE8
                                pend_q[i] <= 1'b0;
                                run_q[i] <= 1'b1;
                                out_q[i] <= 1'b1;
                            end else if (run_q[i]) begin
                                if (count_q[i] <= 16'h0001) begin
                                    out_q[i] <= ~out_q[i];
                                    count_q[i] <= half_count(init_q[i], ~out_q[i]); // RULE8
                                end else begin
                                    count_q[i] <= count_q[i] - 16'h0001;
                                end
                            end
                        end
                        MODE_SW_STROBE: begin
                            if (pend_q[i]) begin
                                count_q[i] <= init_q[i];
                                pend_q[i] <= 1'b0;
                                run_q[i] <= 1'b1;
                            end else if (pulse_q[i]) begin
                                out_q[i] <= 1'b1;
                                pulse_q[i] <= 1'b0;
                            end else if (run_q[i] && s2_q.gate[i]) begin
                                count_q[i] <= dec_count(count_q[i], ctl_q[i].bcd); // RULE10
                                if (count_q[i] == 16'h0001) begin
                                    out_q[i] <= 1'b0; // RULE9
                                    pulse_q[i] <= 1'b1;
                                    run_q[i] <= 1'b0;
                                end
                            end
                        end
                        MODE_HW_STROBE: begin
                            if (trig_q[i]) begin
                                count_q[i] <= init_q[i]; // RULE11
                                pend_q[i] <= 1'b0;
                                run_q[i] <= 1'b1;
                                out_q[i] <= 1'b1;
                                pulse_q[i] <= 1'b0;
                            end else if (pulse_q[i]) begin
                                out_q[i] <= 1'b1;
                                pulse_q[i] <= 1'b0;
                            end else if (run_q[i]) begin
                                count_q[i] <= dec_count(count_q[i], ctl_q[i].bcd);
                                if (count_q[i] == 16'h0001) begin
                                    out_q[i] <= 1'b0; // RULE11
                                    pulse_q[i] <= 1'b1;
                                    run_q[i] <= 1'b0;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (gate_rise[i]) begin
                    trig_q[i] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog relay drive

    logic relay_q;
    logic dog_level;

    assign dog_level = out_q[`DOG_CTR] ^ s2_q.invert;

    always_ff @(posedge clk) begin
        if (srst) begin
            relay_q <= 1'b0;
        end else begin
            relay_q <= dog_enable && dog_level; // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status word and host reads

    logic [7:0] status;
    logic [7:0] rdata_q;
    logic [15:0] rd_val;

    always_comb begin
        status = 8'h00; // RULE21
        status[`ST_HOT] = s2_q.temp_hot; // RULE15
        status[`ST_IN_WINDOW] = ~s2_q.supply_low & ~s2_q.supply_high; // RULE16
        status[`ST_NOT_LOW] = ~s2_q.supply_low; // RULE17
        status[`ST_NOT_HIGH] = ~s2_q.supply_high; // RULE18
        status[`ST_DOG] = s2_q.invert ? out_q[`DOG_CTR] : ~out_q[`DOG_CTR]; // RULE19
        status[`ST_RELAY] = ~relay_q; // RULE20
    end

    always_comb begin
        rd_val = count_q[0];
        for (int i = 0; i < `CTR_NUM; i++) begin
            if (io_req.addr == 3'(i)) begin
                rd_val = latched_q[i] ? latch_q[i] : count_q[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= `RDATA_RST;
            rd_hi_q <= 3'h0;
            latched_q <= 3'h0;
            for (int i = 0; i < `CTR_NUM; i++) begin
                latch_q[i] <= `COUNT_RST;
            end
        end else begin
            for (int i = 0; i < `CTR_NUM; i++) begin
                if (latch_hit[i] && !latched_q[i]) begin
                    latch_q[i] <= count_q[i]; // RULE24
                    latched_q[i] <= 1'b1;
                end else if (ctl_hit[i]) begin
                    rd_hi_q[i] <= 1'b0;
                    latched_q[i] <= 1'b0;
                end else if (io_req.rd && io_req.addr == 3'(i)) begin
                    if (ctl_q[i].acc == `ACC_BOTH) begin
                        rd_hi_q[i] <= ~rd_hi_q[i];
                        latched_q[i] <= latched_q[i] & ~rd_hi_q[i];
                    end else begin
                        latched_q[i] <= 1'b0;
                    end
                end
            end
            if (io_req.rd) begin
                case (io_req.addr)
                    `OFS_CTR0, `OFS_CTR1, `OFS_CTR2: begin
                        if (ctl_q[io_req.addr[1:0]].acc == `ACC_MSB
                            || (ctl_q[io_req.addr[1:0]].acc == `ACC_BOTH
                                && rd_hi_q[io_req.addr[1:0]])) begin
                            rdata_q <= rd_val[15:8];
                        end else begin
                            rdata_q <= rd_val[7:0];
                        end
                    end
                    `OFS_STATUS: rdata_q <= status; // RULE26
                    default: rdata_q <= `UNMAPPED_READ;
                endcase
            end
        end
    end

    assign io_rdata = rdata_q;
    assign ctr_out = out_q;
    assign relay_drive = relay_q;
endmodule : watchdog_monitor_counters

// >>> rtl/mon_cfg.svh
// Offsets, field positions and reset values of the monitor counters
`ifndef MON_CFG_SVH
`define MON_CFG_SVH
`define OFS_CTR0 3'h0
`define OFS_CTR1 3'h1
`define OFS_CTR2 3'h2
`define OFS_CTRL 3'h3
`define OFS_STATUS 3'h4
`define CTL_SEL_HI 7
`define CTL_SEL_LO 6
`define CTL_ACC_HI 5
`define CTL_ACC_LO 4
`define CTL_MODE_HI 3
`define CTL_MODE_LO 1
`define CTL_BCD 0
`define SEL_READBACK 2'h3
`define ACC_LATCH 2'h0
`define ACC_LSB 2'h1
`define ACC_MSB 2'h2
`define ACC_BOTH 2'h3
`define ST_HOT 0
`define ST_IN_WINDOW 1
`define ST_NOT_LOW 2
`define ST_NOT_HIGH 3
`define ST_DOG 4
`define ST_RELAY 5
`define DOG_CTR 2
`define CTR_NUM 3
`define COUNT_RST 16'h0000
`define RDATA_RST 8'h00
`define UNMAPPED_READ 8'h00
`endif

// >>> rtl/mon_pkg.sv
// Types shared by the monitor counter block
package mon_pkg;
    typedef enum logic [2:0] {
        MODE_TC = 3'b000,
        MODE_ONESHOT = 3'b001,
        MODE_RATE = 3'b010,
        MODE_SQUARE = 3'b011,
        MODE_SW_STROBE = 3'b100,
        MODE_HW_STROBE = 3'b101
    } mode_t;
    typedef struct packed {
        logic [1:0] acc;
        mode_t mode;
        logic bcd;
    } ctl_t;
    typedef struct packed {
        logic [2:0] cclk;
        logic [2:0] gate;
        logic temp_hot;
        logic supply_low;
        logic supply_high;
        logic invert;
    } pins_t;
    typedef struct packed {
        logic [2:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } io_req_t;
endpackage : mon_pkg

// >>> sim/mon_checker_assertions.sv
// Port-level assertions for the monitor counter block
`timescale 1ns/10ps
module mon_checker
    import mon_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire mon_pkg::io_req_t io_req,
    input wire mon_pkg::pins_t pins,
    input wire logic dog_enable,
    input wire logic [7:0] io_rdata,
    input wire logic [2:0] ctr_out,
    input wire logic relay_drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    logic [3:0] watch_q;
    logic [2:0] quiet_q;
    logic [2:0] mode2_q;
    logic [1:0] acc2_q;
    logic st_rd;
    logic dog_wr;
    assign st_rd = io_req.rd && io_req.addr == 3'h4;
    assign dog_wr = io_req.wr && io_req.addr == 3'h2 && acc2_q == 2'h1;
    // Cycles since the status pins last moved
    always_ff @(posedge clk) begin
        watch_q <= {pins.temp_hot, pins.supply_low, pins.supply_high, pins.invert};
        if (srst || watch_q != {pins.temp_hot, pins.supply_low, pins.supply_high, pins.invert}) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    // Mode and access of the watchdog counter
    always_ff @(posedge clk) begin
        if (srst) begin
            mode2_q <= 3'h0;
            acc2_q <= 2'h1;
        end else if (io_req.wr && io_req.addr == 3'h3 && io_req.wdata[7:6] == 2'h2) begin
            mode2_q <= io_req.wdata[3:1];
            acc2_q <= io_req.wdata[5:4];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_status_hot: assert property (st_rd && quiet_q >= 3'h4 |=> io_rdata[0] == $past(pins.temp_hot))
        else $error("status hot bit wrong");
    a_status_window: assert property (st_rd && quiet_q >= 3'h4 |=>
        io_rdata[1] == !($past(pins.supply_low) || $past(pins.supply_high)))
        else $error("status window bit wrong");
    a_status_low: assert property (st_rd && quiet_q >= 3'h4 |=> io_rdata[2] == !$past(pins.supply_low))
        else $error("status low bit wrong");
    a_status_high: assert property (st_rd && quiet_q >= 3'h4 |=> io_rdata[3] != $past(pins.supply_high))
        else $error("status high bit wrong");
    a_dog_view_bit: assert property (st_rd && quiet_q >= 3'h4 |=>
        io_rdata[4] == ($past(pins.invert) ? $past(ctr_out[2]) : !$past(ctr_out[2])))
        else $error("status watchdog bit wrong");
    a_relay_view_bit: assert property (st_rd |=> io_rdata[5] == !$past(relay_drive))
        else $error("status relay bit wrong");
    a_relay_off: assert property (!dog_enable [*2] |-> !relay_drive)
        else $error("relay energized while disabled");
    a_status_top_zero: assert property (st_rd |=> io_rdata[7:6] == 2'h0)
        else $error("status top bits not zero");
    a_unmapped_read: assert property (io_req.rd && (io_req.addr == 3'h3 || io_req.addr > 3'h4)
        |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_mode0_low: assert property (dog_wr && mode2_q == 3'h0 |=> !ctr_out[2])
        else $error("mode 0 output not low after load");
    a_mode4_high: assert property (dog_wr && mode2_q == 3'h4 |=> ctr_out[2])
        else $error("mode 4 output not high after load");
endmodule : mon_checker
bind watchdog_monitor_counters mon_checker mon_checker_inst (.clk(clk), .srst(srst),
    .io_req(io_req), .pins(pins), .dog_enable(dog_enable), .io_rdata(io_rdata),
    .ctr_out(ctr_out), .relay_drive(relay_drive));

// >>> sim/watchdog_monitor_counters_bench.sv
// Self-checking bench for the monitor counter block
`timescale 1ns/10ps
module watchdog_monitor_counters_bench;
    import mon_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    io_req_t io_req = '0;
    pins_t pins = '0;
    logic dog_enable = 1'b0;
    logic [7:0] io_rdata;
    logic [2:0] ctr_out;
    logic relay_drive;
    logic [7:0] notes[$];
    logic pend_q = 1'b0;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 32'h8c3a43c9;
    int lows[3];
    always #50 clk = ~clk;
    watchdog_monitor_counters watchdog_monitor_counters_inst (.clk(clk), .srst(srst),
        .io_req(io_req), .pins(pins), .dog_enable(dog_enable), .io_rdata(io_rdata),
        .ctr_out(ctr_out), .relay_drive(relay_drive));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
        n_checks++;
        if (got !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d);
        @(negedge clk);
        io_req.addr = a;
        io_req.wr = w;
        io_req.rd = !w;
        io_req.wdata = d;
        @(negedge clk);
        io_req.wr = 1'b0;
        io_req.rd = 1'b0;
    endtask : bus
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        notes.push_back(e);
        bus(a, 1'b0, 8'h00);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // Low then high on gate 0, long enough to pass the synchronisers
    task automatic retrig();
        pins.gate[0] = 1'b0;
        idle(5);
        pins.gate[0] = 1'b1;
        idle(5);
    endtask : retrig
    // n counter clock pulses on each masked line, noting low outputs after each
    task automatic tick(input logic [2:0] m, input int n);
        repeat (n) begin
            @(negedge clk);
            pins.cclk = m;
            idle(4);
            pins.cclk = 3'h0;
            idle(6);
            for (int i = 0; i < 3; i++) lows[i] += int'(m[i] && !ctr_out[i]);
        end
    endtask : tick
    function automatic logic [7:0] stat(input logic out2);
        logic relay;
        relay = dog_enable && (out2 ^ pins.invert);
        return {2'b00, !relay, pins.invert ? out2 : !out2, !pins.supply_high,
            !pins.supply_low, !(pins.supply_low || pins.supply_high), pins.temp_hot};
    endfunction : stat
    ////////////////////////////////////////////////////////////////////////////////
    // Read results are compared as they appear
    always @(posedge clk) pend_q <= io_req.rd;
    always @(negedge clk) if (pend_q) chk("io_rdata", notes.pop_front(), io_rdata);
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            fail_count++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        idle(8);
        srst = 1'b0;
        for (int k = 0; k < 12; k++) begin
            {pins.temp_hot, pins.supply_low, pins.supply_high, pins.invert} = 4'($random(seed));
            idle(5);
            rd(3'h4, stat(1'b1));
        end
        bus(3'h4, 1'b1, 8'hff);
        for (int a = 3; a < 8; a++) if (a != 4) rd(3'(a), 8'h00);
        rd(3'h4, stat(1'b1));
        $display("status test done");
        pins.invert = 1'b0;
        dog_enable = 1'b1;
        bus(3'h3, 1'b1, 8'h90);
        bus(3'h2, 1'b1, 8'h03);
        tick(3'h4, 6);
        rd(3'h4, stat(1'b0));
        pins.invert = 1'b1;
        pins.gate = 3'h7;
        idle(5);
        rd(3'h4, stat(1'b0));
        tick(3'h4, 2);
        rd(3'h4, stat(1'b0));
        tick(3'h4, 1);
        rd(3'h4, stat(1'b1));
        bus(3'h2, 1'b1, 8'd100);
        tick(3'h4, 60);
        bus(3'h2, 1'b1, 8'd100);
        tick(3'h4, 100);
        rd(3'h4, stat(1'b0));
        tick(3'h4, 1);
        rd(3'h4, stat(1'b1));
        $display("watchdog test done");
        bus(3'h3, 1'b1, 8'h1c);
        bus(3'h0, 1'b1, 8'h03);
        bus(3'h3, 1'b1, 8'h5e);
        bus(3'h1, 1'b1, 8'h05);
        tick(3'h3, 1);
        lows = '{0, 0, 0};
        tick(3'h3, 15);
        chk("rate lows", 8'd5, 8'(lows[0]));
        chk("square lows", 8'd6, 8'(lows[1]));
        pins.gate = 3'h6;
        idle(5);
        lows = '{0, 0, 0};
        tick(3'h1, 6);
        chk("gated rate lows", 8'd0, 8'(lows[0]));
        $display("periodic test done");
        bus(3'h3, 1'b1, 8'h98);
        bus(3'h2, 1'b1, 8'h04);
        tick(3'h4, 1);
        lows = '{0, 0, 0};
        tick(3'h4, 6);
        chk("strobe lows", 8'd1, 8'(lows[2]));
        bus(3'h2, 1'b1, 8'h04);
        pins.gate = 3'h2;
        tick(3'h4, 7);
        pins.gate = 3'h6;
        idle(5);
        lows = '{0, 0, 0};
        tick(3'h4, 3);
        chk("held strobe lows", 8'd0, 8'(lows[2]));
        tick(3'h4, 2);
        chk("resumed strobe lows", 8'd1, 8'(lows[2]));
        $display("strobe test done");
        bus(3'h3, 1'b1, 8'h12);
        bus(3'h0, 1'b1, 8'h03);
        retrig();
        lows = '{0, 0, 0};
        tick(3'h1, 2);
        retrig();
        tick(3'h1, 4);
        chk("oneshot lows", 8'd5, 8'(lows[0]));
        bus(3'h3, 1'b1, 8'h1a);
        bus(3'h0, 1'b1, 8'h03);
        retrig();
        lows = '{0, 0, 0};
        tick(3'h1, 2);
        retrig();
        tick(3'h1, 3);
        chk("retrig strobe lows", 8'd0, 8'(lows[0]));
        tick(3'h1, 1);
        chk("hw strobe lows", 8'd1, 8'(lows[0]));
        $display("oneshot test done");
        test_done();
    end
endmodule : watchdog_monitor_counters_bench
